// File: inc/home_return_map.vh
/*
 * Register offsets, field positions, reset values and method codes
 * for the home position return sequencer.
 * Assumes a 32-bit APB slave decoding byte addresses in paddr[7:0].
 */
`ifndef HOME_RETURN_MAP_VH
`define HOME_RETURN_MAP_VH

`define CFG_OFS          8'h00
`define CTRL_OFS         8'h04
`define AFTER_DOG_OFS    8'h08
`define SHIFT_OFS        8'h0C
`define HOME_DATA_OFS    8'h10
`define STATUS_OFS       8'h14
`define POSITION_OFS     8'h18

`define CFG_METHOD_LSB   0
`define CFG_METHOD_MSB   3
`define CFG_DIR_BIT      4
`define CFG_POL_BIT      8
`define CFG_MASK         32'h0000011F
`define CFG_RESET        32'h00000000

`define CTRL_START_BIT   0
`define CTRL_ABORT_BIT   1

`define STAT_EST_BIT     0
`define STAT_BUSY_BIT    1
`define STAT_MANUAL_BIT  2
`define STAT_DOG_BIT     3
`define STAT_STATE_LSB   8
`define STAT_STATE_MSB   15

`define DIST_RESET       32'h00000000

`define M_DOG            4'h0
`define M_COUNT          4'h1
`define M_DATA_SET       4'h2
`define M_STOPPER        4'h3
`define M_IGNORE         4'h4
`define M_DOG_REAR       4'h5
`define M_COUNT_FRONT    4'h6
`define M_CRADLE         4'h7

// strap read only after its 3-flop filter has settled
`define STRAP_SETTLE     3'h5

`endif

// File: sim/encoder_dog_model.sv
/*
 * Axis model: encoder steps, Z event, proximity dog and stopper.
 * Assumes motion requests of the sequencer; one step every 16 cycles.
 */
`timescale 1ns/100ps
module encoder_dog_model (
  input  wire  pclk,
  input  wire  move_en,
  input  wire  move_dir,
  input  wire  dog_inv,
  input  wire  load,
  input  int   load_pos,
  output logic dog_pin,
  output logic zphase_pin,
  output logic enc_step_pin,
  output logic enc_dir_pin,
  output logic stopper_pin,
  output int   pos
);
  localparam int DOG_LO = 40;
  localparam int DOG_HI = 60;
  localparam int Z_REV = 16;
  localparam int STOP_AT = -30;
  logic [3:0] ph = 4'h0;
  logic       step_q = 1'b0;
  int         pos_i = 0;

  assign pos = pos_i;
  assign dog_pin = ((pos_i >= DOG_LO) && (pos_i <= DOG_HI)) ^ dog_inv;
  assign zphase_pin = (pos_i % Z_REV) == 0;
  assign stopper_pin = pos_i <= STOP_AT;
  assign enc_dir_pin = move_dir;
  assign enc_step_pin = step_q;

  // slow steps so the input filters see every edge
  always @(posedge pclk) begin
    ph <= ph + 4'h1;
    if (load) begin
      pos_i <= load_pos;
    end else if (ph == 4'h0 && move_en && !stopper_pin) begin
      pos_i <= move_dir ? pos_i - 1 : pos_i + 1;
      step_q <= 1'b1;
    end
    if (ph == 4'h8) begin
      step_q <= 1'b0;
    end
  end
endmodule

// File: sim/home_position_return_sequencer_assertions.sv
/*
 * Port checker for the home position return sequencer.
 * Assumes one clock domain; attached by the bind at the foot.
 */
`timescale 1ns/100ps
module home_seq_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire servo_on_pin,
  input wire auto_manual_select,
  input wire abs_system_strap,
  input wire move_en,
  input wire move_creep,
  input wire home_established,
  input wire homing_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_READY_LAT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_INC_NOT_VALID: assert property (
    $rose(presetn) && !abs_system_strap |-> !home_established [*4])
    else $error("home valid after reset in incremental system");
  AST_ABS_VALID: assert property (
    $rose(presetn) && abs_system_strap |-> ##[1:6] home_established)
    else $error("home not kept in absolute system");
  AST_AUTO_NO_START: assert property (
    !auto_manual_select [*8] |-> !$rose(move_en))
    else $error("homing started outside manual mode");
  AST_SERVO_OFF_STOP: assert property (!servo_on_pin [*8] |-> !move_en)
    else $error("motion with servo off");
  AST_START_CLEARS: assert property ($rose(move_en) |-> !home_established)
    else $error("home valid while homing runs");
  AST_DONE_STOPS: assert property ($rose(home_established) |-> !move_en)
    else $error("motion after completion");
  AST_CREEP_MOVING: assert property ($rose(move_creep) |-> move_en)
    else $error("creep without motion");
  AST_BUSY_IS_MOVE: assert property (homing_busy == move_en)
    else $error("busy and motion disagree");

  cover property ($rose(home_established));
  cover property ($rose(move_creep));
  cover property (pslverr);
endmodule

bind home_position_return_sequencer home_seq_checker chk_u (
  .pclk               (pclk),
  .presetn            (presetn),
  .psel               (psel),
  .penable            (penable),
  .pready             (pready),
  .pslverr            (pslverr),
  .servo_on_pin       (servo_on_pin),
  .auto_manual_select (auto_manual_select),
  .abs_system_strap   (abs_system_strap),
  .move_en            (move_en),
  .move_creep         (move_creep),
  .home_established   (home_established),
  .homing_busy        (homing_busy)
);

// File: sim/test_home_position_return_sequencer.sv
/*
 * Bench for the home position return sequencer.
 * Assumes the axis model and the bound port checker.
 */
`timescale 1ns/100ps
`include "home_return_map.vh"
module test_home_position_return_sequencer;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        servo_on_pin = 1'b1;
  logic        auto_manual_select = 1'b1;
  logic        abs_system_strap = 1'b0;
  logic        dog_inv = 1'b0;
  logic        load = 1'b0;
  int          load_pos = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, err_q;
  logic        dog_pin, zphase_pin, enc_step_pin, enc_dir_pin, stopper_pin;
  logic        move_en, move_dir, move_creep, home_established, homing_busy;
  int          pos;
  int          error_cnt = 0;
  int          n_tests = 0;

  home_position_return_sequencer dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dog_pin(dog_pin),
    .zphase_pin(zphase_pin), .enc_step_pin(enc_step_pin), .enc_dir_pin(enc_dir_pin),
    .stopper_pin(stopper_pin), .servo_on_pin(servo_on_pin),
    .auto_manual_select(auto_manual_select), .abs_system_strap(abs_system_strap),
    .move_en(move_en), .move_dir(move_dir), .move_creep(move_creep),
    .home_established(home_established), .homing_busy(homing_busy));
  encoder_dog_model axis_u (.pclk(pclk), .move_en(move_en), .move_dir(move_dir),
    .dog_inv(dog_inv), .load(load), .load_pos(load_pos), .dog_pin(dog_pin),
    .zphase_pin(zphase_pin), .enc_step_pin(enc_step_pin), .enc_dir_pin(enc_dir_pin),
    .stopper_pin(stopper_pin), .pos(pos));

  always #12.5 pclk = ~pclk;

  task check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task report_and_stop();
    $display("errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // one idle edge after each transfer so psel is never set twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready ends this wait; if it never comes, only the watchdog ends it
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    check(pready === 1'b1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task wait_est();
    int k;
    k = 0;
    while (home_established !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    check(home_established === 1'b1, "homing not completed");
  endtask

  task run_home(input logic [3:0] m, input logic dir, input logic pol, input int p0,
                input logic [31:0] aft, input logic [31:0] sh, input int ex,
                input logic mv, input logic d0);
    int d;
    load_pos <= p0;
    load <= 1'b1;
    dog_inv <= !pol;
    @(posedge pclk);
    load <= 1'b0;
    apb(1'b1, `CFG_OFS, {23'h0, pol, 3'h0, dir, m});
    apb(1'b1, `AFTER_DOG_OFS, aft);
    apb(1'b1, `SHIFT_OFS, sh);
    apb(1'b1, `HOME_DATA_OFS, 32'h000001A5);
    apb(1'b1, `CTRL_OFS, 32'h1);
    if (mv) begin
      check(move_en === 1'b1 && move_dir === d0 && move_creep === (m == `M_STOPPER),
            "start direction or speed");
    end
    wait_est();
    d = pos - ex;
    check(d <= 1 && d >= -1, "home position");
    apb(1'b0, `POSITION_OFS, 32'h0);
    check(rd === 32'h000001A5, "position not loaded");
  endtask

  task t_regs();
    check(home_established === 1'b0, "home valid after power-on");
    apb(1'b0, `CFG_OFS, 32'h0);
    check(rd === `CFG_RESET, "config reset value");
    apb(1'b1, `CFG_OFS, 32'hFFFFFFFF);
    apb(1'b0, `CFG_OFS, 32'h0);
    check(rd === `CFG_MASK, "config fields");
    apb(1'b0, 8'h40, 32'h0);
    check(err_q === 1'b1 && rd === 32'h0, "unmapped read");
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(rd[`STAT_MANUAL_BIT] === 1'b1, "manual mode flag");
  endtask

  task t_methods();
    run_home(`M_DOG, 1'b0, 1'b1, 0, 32'h0, 32'h3, 67, 1'b1, 1'b0);
    run_home(`M_DOG, 1'b1, 1'b0, 100, 32'h0, 32'h0, 32, 1'b1, 1'b1);
    run_home(`M_DOG, 1'b0, 1'b1, 50, 32'h0, 32'h0, 64, 1'b1, 1'b1);
    run_home(`M_COUNT, 1'b0, 1'b1, 0, 32'h14, 32'h0, 64, 1'b1, 1'b0);
    run_home(`M_DATA_SET, 1'b0, 1'b1, 77, 32'h0, 32'h0, 77, 1'b0, 1'b0);
    run_home(`M_STOPPER, 1'b1, 1'b1, 0, 32'h0, 32'h0, -30, 1'b1, 1'b1);
    run_home(`M_DOG_REAR, 1'b0, 1'b1, 0, 32'h5, 32'h3, 69, 1'b1, 1'b0);
    run_home(`M_COUNT_FRONT, 1'b0, 1'b1, 0, 32'hA, 32'h2, 52, 1'b1, 1'b0);
    run_home(`M_CRADLE, 1'b0, 1'b1, 0, 32'h0, 32'h0, 48, 1'b1, 1'b0);
  endtask

  task t_refuse();
    auto_manual_select <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1'b1, `CFG_OFS, 32'h0);
    apb(1'b1, `CTRL_OFS, 32'h1);
    repeat (20) @(posedge pclk);
    check(homing_busy === 1'b0, "start outside manual mode");
    auto_manual_select <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b1, `CTRL_OFS, 32'h1);
    repeat (40) @(posedge pclk);
    check(homing_busy === 1'b1 && home_established === 1'b0, "start");
    apb(1'b1, `CTRL_OFS, 32'h2);
    repeat (10) @(posedge pclk);
    check(homing_busy === 1'b0 && home_established === 1'b0, "abort");
    apb(1'b1, `CFG_OFS, {28'h0, `M_IGNORE});
    servo_on_pin <= 1'b0;
    repeat (12) @(posedge pclk);
    servo_on_pin <= 1'b1;
    wait_est();
  endtask

  task t_abs(input logic s);
    abs_system_strap <= s;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    check(home_established === s, "home after power-on");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_regs();
    t_methods();
    t_refuse();
    t_abs(1'b1);
    t_abs(1'b0);
    report_and_stop();
  end

  // about 7500 cycles expected; allow over five times that
  initial begin
    #1000000;
    error_cnt++;
    $display("Error at %0t: timeout", $time);
    report_and_stop();
  end
endmodule

// File: src/home_position_return_sequencer.v
/*
 * Home position return sequencer: APB register slave, homing state machine,
 * position counter and home-established tracking.
 * Assumes single clock pclk at 40 MHz, all pins asynchronous, distances
 * counted in encoder step pulses, motion generation outside this block.
 */
// The implementer's own choices: register access over APB and the register offsets.
// Functional notes
// - incremental system: home unknown after every power-on, homing needed.
// - absolute system: position kept over power loss, no homing needed again; code keeps only the home flag, position resets to 0.
// - start at or past dog: back off automatically, then home; code backs off only when started on the dog.
// - dog type: slow at dog front, home at first Z after rear, plus shift.
// - count type: slow at dog front, after-dog distance, first Z, plus shift.
// - data setting: current position taken as home, no dog used.
// - stopper type: home where the axis stops against the stopper.
// - ignore type: position at servo-on becomes home.
// - dog rear end: after rear edge, after-dog plus shift distance, no Z.
// - count front end: after dog front, after-dog plus shift, no Z.
// - dog cradle: home at first Z after dog front edge; code adds the shift distance after that Z.
// - Z event used internally only, never driven out.
// - configuration holds method, start direction and dog polarity.
// - direction 0 moves toward increasing address, 1 toward decreasing.
// - polarity 0 detects dog with input off, 1 with input on.
// - manual homing mode entered while auto/manual select is on.
// - method digit 0 selects dog type, 1 selects count type.
`timescale 1ns/100ps
`include "home_return_map.vh"
module home_position_return_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        dog_pin,
  input  wire        zphase_pin,
  input  wire        enc_step_pin,
  input  wire        enc_dir_pin,
  input  wire        stopper_pin,
  input  wire        servo_on_pin,
  input  wire        auto_manual_select,
  input  wire        abs_system_strap,
  output reg         move_en,
  output reg         move_dir,
  output reg         move_creep,
  output reg         home_established,
  output reg         homing_busy
);
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_BACK  = 8'h02;
  localparam [7:0] S_SEEK  = 8'h04;
  localparam [7:0] S_REAR  = 8'h08;
  localparam [7:0] S_DIST  = 8'h10;
  localparam [7:0] S_ZWAIT = 8'h20;
  localparam [7:0] S_SHIFT = 8'h40;
  localparam [7:0] S_STOP  = 8'h80;

  wire        dog_lvl;
  wire        z_lvl;
  wire        step_lvl;
  wire        dir_lvl;
  wire        stop_lvl;
  wire        son_lvl;
  wire        manual_lvl;
  wire        strap_lvl;

  reg  [31:0] cfg_reg;
  reg  [31:0] after_dog_reg;
  reg  [31:0] shift_reg;
  reg  [31:0] home_data_reg;
  reg  [31:0] pos_reg;
  reg  [31:0] pos_next;
  reg  [31:0] cnt_reg;
  reg  [31:0] cnt_next;
  reg  [7:0]  state_reg;
  reg  [7:0]  state_next;
  reg         established_reg;
  reg         established_next;
  reg         dog_d_reg;
  reg         z_d_reg;
  reg         step_d_reg;
  reg         son_d_reg;
  reg  [2:0]  settle_reg;
  reg         home_hit;
  reg  [31:0] rd_data;
  reg         rd_err;

  wire [3:0]  method;
  wire        cfg_dir;
  wire        cfg_pol;
  wire        dog_act;
  wire        dog_rise;
  wire        dog_fall;
  wire        z_rise;
  wire        step_rise;
  wire        son_rise;
  wire        apb_access;
  wire        apb_wr;
  wire        start_req;
  wire        abort_req;
  wire        start_ok;

  pin_filter u_dog   (.clk(pclk), .rst_n(presetn), .pin(dog_pin),            .level(dog_lvl));
  pin_filter u_z     (.clk(pclk), .rst_n(presetn), .pin(zphase_pin),         .level(z_lvl));
  pin_filter u_step  (.clk(pclk), .rst_n(presetn), .pin(enc_step_pin),       .level(step_lvl));
  pin_filter u_dir   (.clk(pclk), .rst_n(presetn), .pin(enc_dir_pin),        .level(dir_lvl));
  pin_filter u_stop  (.clk(pclk), .rst_n(presetn), .pin(stopper_pin),        .level(stop_lvl));
  pin_filter u_son   (.clk(pclk), .rst_n(presetn), .pin(servo_on_pin),       .level(son_lvl));
  pin_filter u_man   (.clk(pclk), .rst_n(presetn), .pin(auto_manual_select), .level(manual_lvl));
  pin_filter u_strap (.clk(pclk), .rst_n(presetn), .pin(abs_system_strap),   .level(strap_lvl));

  // three fields of the homing configuration
  assign method  = cfg_reg[`CFG_METHOD_MSB:`CFG_METHOD_LSB];
  assign cfg_dir = cfg_reg[`CFG_DIR_BIT];
  assign cfg_pol = cfg_reg[`CFG_POL_BIT];

  assign dog_act  = cfg_pol ? dog_lvl : ~dog_lvl;
  assign dog_rise = dog_act & ~dog_d_reg;
  assign dog_fall = ~dog_act & dog_d_reg;
  assign z_rise    = z_lvl & ~z_d_reg;
  assign step_rise = step_lvl & ~step_d_reg;
  assign son_rise  = son_lvl & ~son_d_reg;

  // access seen on the first access cycle; writes land on the pready edge only
  assign apb_access = psel & penable & ~pready;
  assign apb_wr     = psel & penable & pready & pwrite;
  assign start_req  = apb_wr & (paddr == `CTRL_OFS) & pwdata[`CTRL_START_BIT];
  assign abort_req  = apb_wr & (paddr == `CTRL_OFS) & pwdata[`CTRL_ABORT_BIT];
  // start accepted only in manual homing mode
  assign start_ok   = start_req & manual_lvl & son_lvl & (state_reg == S_IDLE);

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    home_hit   = 1'b0;
    case (state_reg)
      S_IDLE: begin
        if (start_ok) begin
          cnt_next = 32'h00000000;
          if (method == `M_DATA_SET || method == `M_IGNORE) begin
            home_hit = 1'b1;
          end else if (method == `M_STOPPER) begin
            state_next = S_STOP;
          end else if (dog_act) begin
            // already on the dog, back off first
            state_next = S_BACK;
          end else begin
            state_next = S_SEEK;
          end
        end else if (son_rise && method == `M_IGNORE) begin
          home_hit = 1'b1;
        end
      end
      S_BACK: begin
        if (!dog_act) begin
          state_next = S_SEEK;
        end
      end
      S_SEEK: begin
        if (dog_rise) begin
          cnt_next = 32'h00000000;
          // digit 0 dog type, 1 count type
          if (method == `M_DOG || method == `M_DOG_REAR) begin
            state_next = S_REAR;
          end else if (method == `M_COUNT || method == `M_COUNT_FRONT) begin
            state_next = S_DIST;
          end else begin
            // cradle waits for Z right after the front
            state_next = S_ZWAIT;
          end
        end
      end
      S_REAR: begin
        if (dog_fall) begin
          cnt_next = 32'h00000000;
          // dog type seeks Z after the rear
          if (method == `M_DOG) begin
            state_next = S_ZWAIT;
          end else begin
            state_next = S_DIST;
          end
        end
      end
      S_DIST: begin
        if (cnt_reg >= after_dog_reg) begin
          cnt_next = 32'h00000000;
          if (method == `M_COUNT) begin
            state_next = S_ZWAIT;
          end else begin
            state_next = S_SHIFT;
          end
        end else if (step_rise) begin
          cnt_next = cnt_reg + 32'h00000001;
        end
      end
      S_ZWAIT: begin
        if (z_rise) begin
          cnt_next   = 32'h00000000;
          state_next = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (cnt_reg >= shift_reg) begin
          home_hit   = 1'b1;
          state_next = S_IDLE;
        end else if (step_rise) begin
          cnt_next = cnt_reg + 32'h00000001;
        end
      end
      S_STOP: begin
        if (stop_lvl) begin
          home_hit   = 1'b1;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    // loss of servo-on or an abort drops the sequence without a home
    if (state_reg != S_IDLE && (abort_req || !son_lvl)) begin
      state_next = S_IDLE;
      home_hit   = 1'b0;
    end
  end

  always @* begin
    pos_next = pos_reg;
    if (home_hit) begin
      pos_next = home_data_reg;
    end else if (step_rise) begin
      pos_next = dir_lvl ? pos_reg - 32'h00000001 : pos_reg + 32'h00000001;
    end
  end

  // completion sets, a new start invalidates
  always @* begin
    established_next = established_reg;
    if (home_hit) begin
      established_next = 1'b1;
    end else if (settle_reg == (`STRAP_SETTLE - 3'h1)) begin
      // absolute system keeps the home across power loss
      established_next = strap_lvl;
    end else if (start_ok) begin
      established_next = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= S_IDLE;
      cnt_reg         <= 32'h00000000;
      pos_reg         <= 32'h00000000;
      dog_d_reg       <= 1'b0;
      z_d_reg         <= 1'b0;
      step_d_reg      <= 1'b0;
      son_d_reg       <= 1'b0;
      settle_reg      <= 3'h0;
      established_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      pos_reg    <= pos_next;
      dog_d_reg  <= dog_act;
      z_d_reg    <= z_lvl;
      step_d_reg <= step_lvl;
      son_d_reg  <= son_lvl;
      if (settle_reg != `STRAP_SETTLE) begin
        settle_reg <= settle_reg + 3'h1;
      end
      established_reg <= established_next;
    end
  end

  // direction 0 increments, 1 decrements; back-off runs reversed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_en          <= 1'b0;
      move_dir         <= 1'b0;
      move_creep       <= 1'b0;
      home_established <= 1'b0;
      homing_busy      <= 1'b0;
    end else begin
      move_en          <= (state_next != S_IDLE);
      move_dir         <= (state_next == S_BACK) ? ~cfg_dir : cfg_dir;
      move_creep       <= (state_next != S_IDLE) && (state_next != S_BACK) &&
                          (state_next != S_SEEK);
      home_established <= established_next;
      homing_busy      <= (state_next != S_IDLE);
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (paddr == `CFG_OFS) begin
      rd_data = cfg_reg;
    end else if (paddr == `CTRL_OFS) begin
      rd_data = 32'h00000000;
    end else if (paddr == `AFTER_DOG_OFS) begin
      rd_data = after_dog_reg;
    end else if (paddr == `SHIFT_OFS) begin
      rd_data = shift_reg;
    end else if (paddr == `HOME_DATA_OFS) begin
      rd_data = home_data_reg;
    end else if (paddr == `STATUS_OFS) begin
      rd_data[`STAT_EST_BIT]                   = established_reg;
      rd_data[`STAT_BUSY_BIT]                  = (state_reg != S_IDLE);
      rd_data[`STAT_MANUAL_BIT]                = manual_lvl;
      rd_data[`STAT_DOG_BIT]                   = dog_act;
      rd_data[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_reg;
    end else if (paddr == `POSITION_OFS) begin
      rd_data = pos_reg;
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg       <= `CFG_RESET;
      after_dog_reg <= `DIST_RESET;
      shift_reg     <= `DIST_RESET;
      home_data_reg <= `DIST_RESET;
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & rd_err;
      if (apb_access && !pwrite) begin
        prdata <= rd_data;
      end
      if (apb_wr && !rd_err) begin
        // configuration changes are ignored while a sequence runs
        if (paddr == `CFG_OFS && state_reg == S_IDLE) begin
          cfg_reg <= pwdata & `CFG_MASK;
        end else if (paddr == `AFTER_DOG_OFS) begin
          after_dog_reg <= pwdata;
        end else if (paddr == `SHIFT_OFS) begin
          shift_reg <= pwdata;
        end else if (paddr == `HOME_DATA_OFS) begin
          home_data_reg <= pwdata;
        end
      end
    end
  end
endmodule

// File: src/pin_filter.v
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes pin is asynchronous to clk; level follows once stages 2 and 3 agree.
 */
`timescale 1ns/100ps
module pin_filter (
  input  wire clk,
  input  wire rst_n,
  input  wire pin,
  output reg  level
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level  <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end
endmodule
